// ### rtl/ssc_pkg.sv
// Constants and types for the status and system control register bank.
// Assumes one 50 MHz core clock and a core that drives all requests.
package ssc_pkg;
  localparam logic [7:0] STATUS_ADDR     = 8'h0A;
  localparam logic [7:0] PIN_CTRL_ADDR   = 8'h1E;
  localparam logic [7:0] EDGE_CTRL_ADDR  = 8'h1F;
  localparam int         WDT_TIMEOUT_BIT = 5;
  localparam int         SLEEP_BIT       = 4;
  localparam int         SIGNED_RANGE_BIT = 3;
  localparam int         Z_BIT           = 2;
  localparam int         HALF_CARRY_BIT  = 1;
  localparam int         C_BIT           = 0;
  localparam int         TONE_SEL_BIT    = 2;
  localparam int         EDGE_LSB        = 6;
  localparam logic [7:0] STATUS_MASK     = 8'h3F;
  localparam logic [7:0] STATUS_WR_MASK  = 8'h0F;
  localparam logic [7:0] PIN_CTRL_MASK   = 8'h04;
  localparam logic [7:0] EDGE_CTRL_MASK  = 8'hC0;
  localparam logic [7:0] STATUS_RST      = 8'h00;
  localparam logic [7:0] PIN_CTRL_RST    = 8'h00;
  localparam logic [7:0] EDGE_CTRL_RST   = 8'h80;
  localparam int         CLK_HZ          = 50_000_000;
  localparam int         FAST_OSC_HZ     = 8_000_000;
  localparam int         SLOW_OSC_HZ     = 12_000;
  localparam int         FAST_DIV_CYC    = CLK_HZ / FAST_OSC_HZ;
  localparam int         SLOW_DIV_CYC    = CLK_HZ / SLOW_OSC_HZ;

  typedef enum logic [1:0] {
    SSC_OP_ADD   = 2'b00,
    SSC_OP_SUB   = 2'b01,
    SSC_OP_LOGIC = 2'b10,
    SSC_OP_ROT   = 2'b11
  } ssc_op_t;

  typedef enum logic [1:0] {
    SSC_EDGE_OFF  = 2'b00,
    SSC_EDGE_RISE = 2'b01,
    SSC_EDGE_FALL = 2'b10,
    SSC_EDGE_BOTH = 2'b11
  } ssc_edge_t;

  typedef struct packed {
    logic       valid;
    ssc_op_t    op;
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic [7:0] res;
    logic       shift_out;
  } ssc_alu_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ssc_reg_req_t;

  typedef struct packed {
    logic       watchdog_clear_instr;
    logic       sleep;
    logic       wake;
    logic       wdt_timeout;
    logic       wdt_en;
    logic       tmr_en;
  } ssc_sys_t;
endpackage

// ### rtl/ssc_regs.sv
// Status flags, pin function and interrupt edge control, oscillator run control.
// Assumes the execution core drives requests on i_clk; only the
// interrupt pin comes from outside and is synchronised here.
`timescale 1ns/1ps
module ssc_regs #(
  parameter int SLOW_DIV = ssc_pkg::SLOW_DIV_CYC,
  parameter int FAST_DIV = ssc_pkg::FAST_DIV_CYC
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire ssc_pkg::ssc_reg_req_t i_req,
  input  wire ssc_pkg::ssc_alu_t     i_alu,
  input  wire ssc_pkg::ssc_sys_t     i_sys,
  input  wire logic                  i_gpio_out,
  input  wire logic                  i_gpio_oe,
  input  wire logic                  i_tone_output,
  input  wire logic                  i_ext_irq_pin,
  output logic [7:0]                 o_rdata,
  output logic [7:0]                 o_status,
  output logic                       o_port_a_bit6_out,
  output logic                       o_port_a_bit6_oe,
  output ssc_pkg::ssc_edge_t         o_ext_irq_edge_select,
  output logic                       o_ext_irq_req,
  output logic                       o_fast_osc_run,
  output logic                       o_sys_tick,
  output logic                       o_slow_osc_run,
  output logic                       o_slow_tick
);
  import ssc_pkg::*;

  // Both divider counters are 16 bits wide
  if (SLOW_DIV < 2 || FAST_DIV < 2 ||
      SLOW_DIV > 65535 || FAST_DIV > 65535) begin : g_div_check
    $error("ssc_regs: divider out of range");
  end

  function automatic logic [10:0] add9(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
    logic [4:0] lo;
    logic [7:0] s7;
    logic [8:0] s8;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    s7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
    s8 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    // {carry, half carry, overflow, sum}
    add9 = {s8[8], lo[4], s8[8] ^ s7[7], s8[7:0]};
  endfunction

  logic [7:0]  status_r;
  logic [7:0]  status_nxt;
  logic [7:0]  pin_ctrl_r;
  logic [7:0]  edge_ctrl_r;
  logic        sleep_r;
  logic        sleep_nxt;
  logic [2:0]  irq_sync_r;
  logic [15:0] slow_cnt_r;
  logic [15:0] fast_cnt_r;

  wire         wr_status = i_req.wr && i_req.addr == STATUS_ADDR;
  wire         wr_pin    = i_req.wr && i_req.addr == PIN_CTRL_ADDR;
  wire         wr_edge   = i_req.wr && i_req.addr == EDGE_CTRL_ADDR;
  wire  [7:0]  rd_mux    = (i_req.addr == STATUS_ADDR)    ? status_r    :
                           (i_req.addr == PIN_CTRL_ADDR)  ? pin_ctrl_r  :
                           (i_req.addr == EDGE_CTRL_ADDR) ? edge_ctrl_r : 8'h00;
  wire         is_sub    = i_alu.op == SSC_OP_SUB;
  wire  [10:0] arith     = add9(i_alu.a, is_sub ? ~i_alu.b : i_alu.b, i_alu.cin);
  wire  [3:0]  arith_fl  = {arith[8], arith[7:0] == 8'h00, arith[9], arith[10]};

  // Arithmetic flags as {signed range, zero, half carry, carry}
  logic [3:0] flag_nxt;
  always_comb begin
    flag_nxt = status_r[3:0];
    if (i_alu.valid) begin
      unique case (i_alu.op)
        SSC_OP_ADD,
        SSC_OP_SUB:   flag_nxt = arith_fl;
        SSC_OP_LOGIC: flag_nxt[Z_BIT] = i_alu.res == 8'h00;
        SSC_OP_ROT:   flag_nxt[C_BIT] = i_alu.shift_out;
      endcase
    end
    if (wr_status) begin
      flag_nxt = i_req.wdata[3:0] & STATUS_WR_MASK[3:0];
    end
  end

  wire timeout_nxt    = i_sys.wdt_timeout ||
                        (status_r[WDT_TIMEOUT_BIT] && !i_sys.watchdog_clear_instr && !i_sys.sleep);
  wire sleep_flag_nxt = i_sys.sleep || (status_r[SLEEP_BIT] && !i_sys.watchdog_clear_instr);

  assign status_nxt = {2'b00, timeout_nxt, sleep_flag_nxt, flag_nxt} & STATUS_MASK;
  assign sleep_nxt  = i_sys.sleep || (sleep_r && !i_sys.wake);

  wire slow_run_nxt = !sleep_nxt || i_sys.wdt_en || i_sys.tmr_en;
  wire slow_wrap    = slow_cnt_r == 16'(SLOW_DIV - 1);
  wire fast_wrap    = fast_cnt_r == 16'(FAST_DIV - 1);
  wire irq_rise     = irq_sync_r[1] && !irq_sync_r[2];
  wire irq_fall     = !irq_sync_r[1] && irq_sync_r[2];
  wire [1:0] edge_f = edge_ctrl_r[EDGE_LSB +: 2];
  wire irq_hit      = (edge_f[0] && irq_rise) || (edge_f[1] && irq_fall);
  wire tone_sel     = pin_ctrl_r[TONE_SEL_BIT];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      status_r    <= STATUS_RST;
      pin_ctrl_r  <= PIN_CTRL_RST;
      edge_ctrl_r <= EDGE_CTRL_RST;
    end else begin
      status_r <= status_nxt;
      if (wr_pin) begin
        pin_ctrl_r <= i_req.wdata & PIN_CTRL_MASK;
      end
      if (wr_edge) begin
        edge_ctrl_r <= i_req.wdata & EDGE_CTRL_MASK;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_req.rd) begin
      o_rdata <= rd_mux;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sleep_r        <= 1'b0;
      o_fast_osc_run <= 1'b1;
      o_slow_osc_run <= 1'b1;
    end else begin
      sleep_r        <= sleep_nxt;
      o_fast_osc_run <= !sleep_nxt;
      o_slow_osc_run <= slow_run_nxt;
    end
  end

  // Divider models of both oscillators
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      fast_cnt_r <= 16'h0000;
      o_sys_tick <= 1'b0;
    end else begin
      fast_cnt_r <= (!o_fast_osc_run || fast_wrap) ? 16'h0000 : fast_cnt_r + 16'h0001;
      o_sys_tick <= o_fast_osc_run && fast_wrap;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      slow_cnt_r  <= 16'h0000;
      o_slow_tick <= 1'b0;
    end else begin
      slow_cnt_r  <= (!o_slow_osc_run || slow_wrap) ? 16'h0000 : slow_cnt_r + 16'h0001;
      o_slow_tick <= o_slow_osc_run && slow_wrap;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_sync_r            <= 3'h0;
      o_ext_irq_req         <= 1'b0;
      o_ext_irq_edge_select <= ssc_edge_t'(EDGE_CTRL_RST[EDGE_LSB +: 2]);
    end else begin
      irq_sync_r            <= {irq_sync_r[1:0], i_ext_irq_pin};
      o_ext_irq_req         <= irq_hit;
      o_ext_irq_edge_select <= ssc_edge_t'(edge_f);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_status          <= STATUS_RST;
      o_port_a_bit6_out <= 1'b0;
      o_port_a_bit6_oe  <= 1'b0;
    end else begin
      o_status          <= status_nxt;
      o_port_a_bit6_out <= tone_sel ? i_tone_output : i_gpio_out;
      o_port_a_bit6_oe  <= tone_sel ? 1'b1 : i_gpio_oe;
    end
  end

  // Reference flag values, worked out apart from add9
  wire  [8:0]  chk_sum    = {1'b0, i_alu.a} + {1'b0, i_alu.b} + {8'h00, i_alu.cin};
  wire         chk_zero   = chk_sum[7:0] == 8'h00;
  wire         chk_ov     = (i_alu.a[7] == i_alu.b[7]) && (chk_sum[7] != i_alu.a[7]);
  wire  [4:0]  chk_lo     = {1'b0, i_alu.a[3:0]} + {1'b0, i_alu.b[3:0]} + {4'h0, i_alu.cin};
  wire         chk_hc     = chk_lo[4];
  wire         chk_nob    = {1'b0, i_alu.a} >= {1'b0, i_alu.b} + {8'h00, !i_alu.cin};
  wire         chk_sub_hc = {1'b0, i_alu.a[3:0]} >= {1'b0, i_alu.b[3:0]} + {4'h0, !i_alu.cin};
  wire         addr_hit   = i_req.addr == STATUS_ADDR || i_req.addr == PIN_CTRL_ADDR ||
                            i_req.addr == EDGE_CTRL_ADDR;
  wire         add_go     = i_alu.valid && i_alu.op == SSC_OP_ADD && !wr_status;
  wire         sub_go     = i_alu.valid && i_alu.op == SSC_OP_SUB && !wr_status;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_timeout_set: assert property (i_sys.wdt_timeout |=> status_r[WDT_TIMEOUT_BIT])
    else $error("timeout flag not set");
  a_timeout_clear: assert property ((i_sys.watchdog_clear_instr || i_sys.sleep) && !i_sys.wdt_timeout
    |=> !status_r[WDT_TIMEOUT_BIT]) else $error("timeout flag not cleared");
  a_sleep_flag_set: assert property (i_sys.sleep |=> status_r[SLEEP_BIT] && sleep_r)
    else $error("sleep flag not set");
  a_sleep_flag_clear: assert property (i_sys.watchdog_clear_instr && !i_sys.sleep
    |=> !status_r[SLEEP_BIT]) else $error("sleep flag not cleared");
  a_add_carry: assert property (i_alu.valid && i_alu.op == SSC_OP_ADD && !wr_status
    |=> status_r[C_BIT] == (({1'b0, $past(i_alu.a)} + {1'b0, $past(i_alu.b)}
        + {8'h00, $past(i_alu.cin)}) > 9'h0FF)) else $error("carry wrong");
  a_logic_zero: assert property (i_alu.valid && i_alu.op == SSC_OP_LOGIC && !wr_status
    |=> status_r[Z_BIT] == ($past(i_alu.res) == 8'h00)) else $error("zero wrong");
  a_rot_carry: assert property (i_alu.valid && i_alu.op == SSC_OP_ROT && !wr_status
    |=> status_r[C_BIT] == $past(i_alu.shift_out) && $stable(status_r[3:1]))
    else $error("rotate carry wrong");
  a_write_keeps_sys: assert property (wr_status && !i_sys.sleep && !i_sys.watchdog_clear_instr
    && !i_sys.wdt_timeout |=> $stable(status_r[5:4])) else $error("system flag written");
  a_unused_zero: assert property (status_r[7:6] == 2'b00 && (pin_ctrl_r & 8'hFB) == 8'h00
    && edge_ctrl_r[5:0] == 6'h00) else $error("unused bit set");
  a_tone_route: assert property (##1 o_port_a_bit6_out ==
    ($past(tone_sel) ? $past(i_tone_output) : $past(i_gpio_out))) else $error("pin route");
  a_edge_off: assert property (edge_f == 2'b00 |=> !o_ext_irq_req)
    else $error("irq with edge off");
  a_sleep_stops_clk: assert property (sleep_r |-> !o_fast_osc_run ##1 !o_sys_tick)
    else $error("clock runs in sleep");
  a_slow_off_rule: assert property (!o_slow_osc_run |-> sleep_r)
    else $error("slow osc off while awake");
  a_slow_needs_off: assert property (!o_slow_osc_run
    |-> !$past(i_sys.wdt_en) && !$past(i_sys.tmr_en))
    else $error("slow osc off while in use");

  // Arithmetic flag checks
  a_add_range: assert property (add_go
    |=> status_r[SIGNED_RANGE_BIT] == $past(chk_ov))
    else $error("overflow flag wrong");
  a_add_zero: assert property (add_go
    |=> status_r[Z_BIT] == $past(chk_zero))
    else $error("add zero flag wrong");
  a_add_half: assert property (add_go
    |=> status_r[HALF_CARRY_BIT] == $past(chk_hc))
    else $error("add half carry wrong");
  a_sub_borrow: assert property (sub_go
    |=> status_r[C_BIT] == $past(chk_nob))
    else $error("subtract carry wrong");
  a_sub_half: assert property (sub_go
    |=> status_r[HALF_CARRY_BIT] == $past(chk_sub_hc))
    else $error("subtract half carry wrong");
  a_status_write: assert property (wr_status
    |=> {4'h0, status_r[3:0]} == ($past(i_req.wdata) & 8'h0F))
    else $error("status write lost");

  // Register read checks
  a_unmapped_read: assert property (i_req.rd && !addr_hit
    |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_pin_read_bits: assert property (i_req.rd && i_req.addr == PIN_CTRL_ADDR
    |=> (o_rdata & 8'hFB) == 8'h00)
    else $error("pin control spare bit set");
  a_edge_read_bits: assert property (i_req.rd && i_req.addr == EDGE_CTRL_ADDR
    |=> (o_rdata & 8'h3F) == 8'h00)
    else $error("edge control spare bit set");

  // Pin, interrupt and clock checks
  a_tone_oe: assert property (tone_sel
    |=> o_port_a_bit6_oe)
    else $error("tone pin not driven");
  a_gpio_oe: assert property (!tone_sel
    |=> o_port_a_bit6_oe == $past(i_gpio_oe))
    else $error("port enable wrong");
  a_rise_only: assert property (edge_f == 2'b01 && irq_fall
    |=> !o_ext_irq_req)
    else $error("irq on falling edge");
  a_fall_only: assert property (edge_f == 2'b10 && irq_rise
    |=> !o_ext_irq_req)
    else $error("irq on rising edge");
  a_both_edges: assert property (edge_f == 2'b11 && (irq_rise || irq_fall)
    |=> o_ext_irq_req)
    else $error("irq missed on either edge");
  a_tick_gap: assert property (o_sys_tick
    |=> !o_sys_tick)
    else $error("system tick too long");
  a_slow_tick_gap: assert property (o_slow_tick
    |=> !o_slow_tick)
    else $error("slow tick too long");

  c_sleep_wake: cover property (i_sys.sleep ##[1:20] i_sys.wake);
  c_timeout_seen: cover property (i_sys.wdt_timeout ##1 status_r[WDT_TIMEOUT_BIT]);
  c_status_keep: cover property (wr_status && status_r[SLEEP_BIT] ##1 status_r[SLEEP_BIT]);
  c_slow_off: cover property (sleep_r && !o_slow_osc_run);
  c_both_edges: cover property (edge_f == 2'b11 && o_ext_irq_req);
endmodule

// ### testbench/ssc_core_model.sv
// Execution core model: register, flag and system event requests.
// Assumes requests are sampled on the rising edge of i_clk.
`timescale 1ns/1ps
module ssc_core_model (
  input  wire logic             i_clk,
  input  wire logic [7:0]       i_rdata,
  output ssc_pkg::ssc_reg_req_t o_req,
  output ssc_pkg::ssc_alu_t     o_alu,
  output ssc_pkg::ssc_sys_t     o_sys
);
  import ssc_pkg::*;
  initial begin
    o_req = '0;
    o_alu = '0;
    o_sys = '0;
  end
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) #1;
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk) #1;
    o_req.wr = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk) #1;
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk) #1;
    o_req.rd = 1'b0;
    d = i_rdata;
  endtask
  task automatic alu(input ssc_op_t op, input logic [7:0] a, input logic [7:0] b,
                     input logic cin, input logic [7:0] res, input logic so);
    @(posedge i_clk) #1;
    o_alu = '{valid: 1'b1, op: op, a: a, b: b, cin: cin, res: res, shift_out: so};
    @(posedge i_clk) #1;
    o_alu.valid = 1'b0;
  endtask
  // Pulses last one cycle, enables stay as given
  task automatic sys(input ssc_sys_t s);
    @(posedge i_clk) #1;
    o_sys = s;
    @(posedge i_clk) #1;
    o_sys = '{0, 0, 0, 0, s.wdt_en, s.tmr_en};
  endtask
endmodule

// ### testbench/tb.sv
// Self-checking bench for the status and system control registers.
// Assumes the core model drives all request ports.
`timescale 1ns/1ps
module tb;
  import ssc_pkg::*;
  logic          clk = 0;
  logic          rst_n = 0;
  logic          gpio_out = 0;
  logic          gpio_oe = 0;
  logic          tone = 0;
  logic          irq_pin = 0;
  logic [7:0]    rdata, status, d;
  logic          p6_out, p6_oe, irq_req, fast_run, sys_tick, slow_run, slow_tick;
  ssc_edge_t     edge_sel;
  ssc_reg_req_t  req;
  ssc_alu_t      alu;
  ssc_sys_t      sys;
  int            errors = 0;
  int            samples_checked = 0;
  localparam int FAST_DIV_TB = 2;
  localparam int SLOW_DIV_TB = 8;
  always #10 clk = ~clk;
  ssc_core_model ssc_core_model_i (.i_clk(clk), .i_rdata(rdata), .o_req(req),
    .o_alu(alu), .o_sys(sys));
  ssc_regs #(.SLOW_DIV(SLOW_DIV_TB), .FAST_DIV(FAST_DIV_TB)) ssc_regs_i (.i_clk(clk),
    .i_rst_n(rst_n),
    .i_req(req), .i_alu(alu), .i_sys(sys), .i_gpio_out(gpio_out), .i_gpio_oe(gpio_oe),
    .i_tone_output(tone), .i_ext_irq_pin(irq_pin), .o_rdata(rdata), .o_status(status),
    .o_port_a_bit6_out(p6_out), .o_port_a_bit6_oe(p6_oe), .o_ext_irq_edge_select(edge_sel),
    .o_ext_irq_req(irq_req), .o_fast_osc_run(fast_run), .o_sys_tick(sys_tick),
    .o_slow_osc_run(slow_run), .o_slow_tick(slow_tick));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_reset;
    chk(edge_sel, 2'b10);
    chk({fast_run, slow_run}, 2'b11);
    ssc_core_model_i.reg_rd(STATUS_ADDR, d); chk(d, 8'h00);
    ssc_core_model_i.reg_rd(PIN_CTRL_ADDR, d); chk(d, 8'h00);
    ssc_core_model_i.reg_rd(EDGE_CTRL_ADDR, d); chk(d, 8'h80);
    ssc_core_model_i.reg_rd(8'h55, d); chk(d, 8'h00);
    ssc_core_model_i.reg_wr(STATUS_ADDR, 8'hFF);
    ssc_core_model_i.reg_rd(STATUS_ADDR, d); chk(d, 8'h0F);
  endtask
  task automatic t_alu;
    ssc_core_model_i.alu(SSC_OP_ADD, 8'h7F, 8'h01, 0, 0, 0); chk(status, 8'h0A);
    ssc_core_model_i.alu(SSC_OP_ADD, 8'hFF, 8'h01, 0, 0, 0); chk(status, 8'h07);
    ssc_core_model_i.alu(SSC_OP_SUB, 8'h03, 8'h05, 1, 0, 0); chk(status, 8'h00);
    ssc_core_model_i.alu(SSC_OP_SUB, 8'h05, 8'h03, 1, 0, 0); chk(status, 8'h03);
    ssc_core_model_i.alu(SSC_OP_LOGIC, 0, 0, 0, 8'h00, 0); chk(status, 8'h07);
    ssc_core_model_i.alu(SSC_OP_ROT, 0, 0, 0, 8'h00, 0); chk(status, 8'h06);
  endtask
  task automatic t_sys;
    ssc_core_model_i.sys('{0, 0, 0, 1, 1, 0}); chk(status[5:4], 2'b10);
    ssc_core_model_i.sys('{0, 1, 0, 0, 1, 0}); chk(status[5:4], 2'b01);
    chk({fast_run, slow_run}, 2'b01);
    ssc_core_model_i.sys('{0, 0, 0, 0, 0, 0}); chk(slow_run, 0);
    ssc_core_model_i.sys('{0, 0, 0, 0, 0, 1}); chk(slow_run, 1);
    ssc_core_model_i.sys('{0, 0, 1, 0, 1, 0}); chk(fast_run, 1);
    ssc_core_model_i.sys('{1, 0, 0, 0, 1, 0}); chk(status[5:4], 2'b00);
  endtask
  task automatic t_ticks;
    int nf;
    int ns;
    nf = 0;
    ns = 0;
    for (int c = 0; c < 2 * SLOW_DIV_TB; c++) begin
      @(posedge clk) #1;
      nf += sys_tick;
      ns += slow_tick;
    end
    chk(nf, 2 * SLOW_DIV_TB / FAST_DIV_TB);
    chk(ns, 2);
    ssc_core_model_i.sys('{0, 1, 0, 0, 0, 0}); chk(slow_run, 0);
    nf = 0;
    ns = 0;
    for (int c = 0; c < 2 * SLOW_DIV_TB; c++) begin
      @(posedge clk) #1;
      nf += sys_tick;
      ns += slow_tick;
    end
    chk(nf, 0);
    chk(ns, 0);
    ssc_core_model_i.sys('{0, 0, 1, 0, 0, 0}); chk(fast_run, 1);
    ssc_core_model_i.reg_wr(STATUS_ADDR, 8'h00);
    ssc_core_model_i.reg_rd(STATUS_ADDR, d); chk(d, 8'h10);
  endtask
  task automatic t_pin;
    ssc_core_model_i.reg_wr(PIN_CTRL_ADDR, 8'hFF);
    ssc_core_model_i.reg_rd(PIN_CTRL_ADDR, d); chk(d, 8'h04);
    tone = 1;
    repeat (2) @(posedge clk);
    #1 chk({p6_out, p6_oe}, 2'b11);
    tone = 0;
    ssc_core_model_i.reg_wr(PIN_CTRL_ADDR, 8'h00);
    gpio_out = 1;
    repeat (2) @(posedge clk);
    #1 chk({p6_out, p6_oe}, 2'b10);
    gpio_out = 0;
    gpio_oe = 1;
    repeat (2) @(posedge clk);
    #1 chk({p6_out, p6_oe}, 2'b01);
  endtask
  task automatic t_edge;
    int n;
    for (int k = 0; k < 4; k++) begin
      n = 0;
      ssc_core_model_i.reg_wr(EDGE_CTRL_ADDR, {k[1:0], 6'h3F});
      ssc_core_model_i.reg_rd(EDGE_CTRL_ADDR, d); chk(d, {k[1:0], 6'h00});
      chk(edge_sel, k[1:0]);
      for (int c = 0; c < 20; c++) begin
        @(posedge clk) #1;
        irq_pin = (c < 10);
        n += irq_req;
      end
      chk(n, k[0] + k[1]);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    t_reset();
    t_alu();
    t_sys();
    t_ticks();
    t_pin();
    t_edge();
    close_out();
  end
  initial begin
    #1ms;
    errors++;
    close_out();
  end
endmodule
